// file: hw/eeprom_link_regs.svh
// Constants for the two-wire serial memory slave: codes, counts and timing.
// Assumes inclusion by bare name from the design file only.
`ifndef EEPROM_LINK_REGS_SVH
`define EEPROM_LINK_REGS_SVH

// Fixed device code in the upper nibble of the control byte
`define DEV_CODE 4'ha
// Direction bit value that asks for a read
`define DIR_READ 1'b1
// Bit counter positions within one nine-clock byte slot
`define CNT_LAST_BIT 4'h7
`define CNT_BYTE_DONE 4'h8
`define CNT_ACK_CLK 4'h9
`define CNT_ACK_DONE 4'ha
// Longest self-timed erase-then-write cycle, and system clock rate
`define WR_TIME_MS 10
`define CLK_FREQ_KHZ 125000
// Reset values
`define PTR_RESET 8'h00
`define CNT_RESET 4'h0
`define TIMER_RESET 24'h00_0000

`endif

// file: hw/eeprom_link_pkg.sv
// Types for the two-wire serial memory slave.
// Assumes the constants header is compiled alongside.
package eeprom_link_pkg;

	// Gray codes along idle, control, address, data
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CTRL = 3'h1,
		ST_ADDR = 3'h3,
		ST_WDATA = 3'h2,
		ST_RDATA = 3'h6,
		ST_WAIT = 3'h7
	} link_state_t;

	typedef struct packed {
		logic scl_s1;
		logic scl_s2;
		logic scl_p;
		logic sda_s1;
		logic sda_s2;
		logic sda_p;
		logic wp_s1;
		logic wp_s2;
		logic [2:0] sel_s1;
		logic [2:0] sel_s2;
		logic done_s1;
		logic done_s2;
		logic done_p;
		link_state_t state;
		logic [3:0] cnt;
		logic [7:0] shreg;
		logic [7:0] ptr;
		logic [7:0][7:0] page_buf;
		logic [7:0] valid;
		logic dirty;
		logic pend;
		logic req_tgl;
		logic sda_oe;
		logic sda_lvl;
	} link_regs_t;

	typedef struct packed {
		logic req_s1;
		logic req_s2;
		logic req_p;
		logic busy;
		logic [23:0] cnt;
		logic done_tgl;
	} sys_regs_t;

endpackage : eeprom_link_pkg

// file: hw/i2c_eeprom_slave_256x8.sv
// Two-wire serial slave for a 256 x 8 memory with page buffer and write timer.
// Assumes an open-drain bus resolved outside; link_clk_in oversamples the pins.
`include "eeprom_link_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module i2c_eeprom_slave_256x8 #(
	parameter int unsigned WR_CYCLES = `WR_TIME_MS * `CLK_FREQ_KHZ
) (
	// System clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Link sampling clock
	input wire logic link_clk_in,
	// Serial bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	// Straps
	input wire logic chip_sel_bit0_in,
	input wire logic chip_sel_bit1_in,
	input wire logic chip_sel_bit2_in,
	input wire logic write_protect_in,
	// Status
	output logic busy_out
);

	eeprom_link_pkg::link_regs_t lq;
	eeprom_link_pkg::link_regs_t ld;
	eeprom_link_pkg::sys_regs_t sq;
	eeprom_link_pkg::sys_regs_t sd;
	logic [7:0] mem [256];
	logic [7:0] rd_byte;
	logic rst_l1;
	logic rst_l2;
	logic start_w;
	logic stop_w;
	logic rise_w;
	logic fall_w;
	logic commit_w;
	logic ctrl_match_w;

	assign sda_out = lq.sda_lvl;
	assign sda_oe_out = lq.sda_oe;
	assign busy_out = sq.busy;

	// Reset brought into the link domain as a level
	// Two flops so link logic never leaves reset on a half-settled level
	always_ff @(posedge link_clk_in) begin
		rst_l1 <= rst_n_in;
		rst_l2 <= rst_l1;
	end

	assign start_w = lq.scl_p & lq.scl_s2 & lq.sda_p & ~lq.sda_s2;
	assign stop_w = lq.scl_p & lq.scl_s2 & ~lq.sda_p & lq.sda_s2;
	assign rise_w = ~lq.scl_p & lq.scl_s2;
	assign fall_w = lq.scl_p & ~lq.scl_s2;
	assign ctrl_match_w = (lq.shreg[7:4] == `DEV_CODE) && (lq.shreg[3:1] == lq.sel_s2);
	assign rd_byte = mem[lq.ptr];

	always_comb begin
		ld = lq;
		commit_w = 1'b0;
		ld.scl_s1 = scl_in;
		ld.scl_s2 = lq.scl_s1;
		ld.scl_p = lq.scl_s2;
		ld.sda_s1 = sda_in;
		ld.sda_s2 = lq.sda_s1;
		ld.sda_p = lq.sda_s2;
		ld.wp_s1 = write_protect_in;
		ld.wp_s2 = lq.wp_s1;
		ld.sel_s1 = {chip_sel_bit2_in, chip_sel_bit1_in, chip_sel_bit0_in};
		ld.sel_s2 = lq.sel_s1;
		ld.done_s1 = sq.done_tgl;
		ld.done_s2 = lq.done_s1;
		ld.done_p = lq.done_s2;
		// Commit buffer when timer reports end
		if (lq.done_s2 != lq.done_p) begin
			commit_w = lq.pend;
			ld.pend = 1'b0;
			ld.valid = 8'h00;
		end
		if (start_w) begin
			// Repeated start drops data, keeps pointer
			ld.state = eeprom_link_pkg::ST_CTRL;
			ld.cnt = `CNT_RESET;
			ld.sda_oe = 1'b0;
			ld.dirty = 1'b0;
		end else if (stop_w) begin
			// Launch write cycle; not when protected
			if (lq.state == eeprom_link_pkg::ST_WDATA && lq.dirty && !lq.wp_s2 && !lq.pend) begin
				ld.pend = 1'b1;
				ld.req_tgl = ~lq.req_tgl;
			end
			ld.state = eeprom_link_pkg::ST_IDLE;
			ld.sda_oe = 1'b0;
			ld.dirty = 1'b0;
		end else if (lq.state != eeprom_link_pkg::ST_IDLE && lq.state != eeprom_link_pkg::ST_WAIT) begin
			if (rise_w) begin
				if (lq.cnt <= `CNT_LAST_BIT) begin
					if (lq.state != eeprom_link_pkg::ST_RDATA) begin
						ld.shreg = {lq.shreg[6:0], lq.sda_s2};
					end
					ld.cnt = lq.cnt + 4'h1;
				end else if (lq.cnt == `CNT_ACK_CLK) begin
					// No acknowledge from master ends the read
					if (lq.state == eeprom_link_pkg::ST_RDATA && lq.sda_s2) begin
						ld.state = eeprom_link_pkg::ST_WAIT;
					end else begin
						ld.cnt = `CNT_ACK_DONE;
					end
				end
			end else if (fall_w) begin
				if (lq.cnt == `CNT_BYTE_DONE) begin
					ld.cnt = `CNT_ACK_CLK;
					unique case (lq.state)
						eeprom_link_pkg::ST_RDATA: begin
							ld.sda_oe = 1'b0;
						end
						eeprom_link_pkg::ST_CTRL: begin
							// Acknowledge only on match; never while busy
							if (ctrl_match_w && !lq.pend) begin
								ld.sda_oe = 1'b1;
								ld.state = (lq.shreg[0] == `DIR_READ) ?
									eeprom_link_pkg::ST_RDATA : eeprom_link_pkg::ST_ADDR;
							end else begin
								ld.state = eeprom_link_pkg::ST_WAIT;
							end
						end
						eeprom_link_pkg::ST_ADDR: begin
							ld.ptr = lq.shreg;
							ld.valid = 8'h00;
							ld.sda_oe = 1'b1;
							ld.state = eeprom_link_pkg::ST_WDATA;
						end
						eeprom_link_pkg::ST_WDATA: begin
							// Buffer the byte; slot reuse overwrites
							ld.page_buf[lq.ptr[2:0]] = lq.shreg;
							ld.valid[lq.ptr[2:0]] = 1'b1;
							ld.ptr = {lq.ptr[7:3], lq.ptr[2:0] + 3'h1};
							ld.dirty = 1'b1;
							ld.sda_oe = 1'b1;
						end
						default: begin
							ld.sda_oe = 1'b0;
						end
					endcase
				end else if (lq.cnt == `CNT_ACK_DONE) begin
					ld.cnt = `CNT_RESET;
					ld.sda_oe = 1'b0;
					if (lq.state == eeprom_link_pkg::ST_RDATA) begin
						// Pointer kept at last access plus one
						// Next byte out; pointer wraps by width
						ld.shreg = rd_byte;
						ld.ptr = lq.ptr + 8'h01;
						ld.sda_oe = ~rd_byte[7];
					end
				end else if (lq.state == eeprom_link_pkg::ST_RDATA && lq.cnt != `CNT_RESET &&
					lq.cnt <= `CNT_LAST_BIT) begin
					// Next data bit changes only after falling clock
					ld.shreg = {lq.shreg[6:0], 1'b0};
					ld.sda_oe = ~lq.shreg[6];
				end
			end
		end
	end

	always_ff @(posedge link_clk_in) begin
		if (!rst_l2) begin
			lq <= '0;
			lq.scl_s1 <= 1'b1;
			lq.scl_s2 <= 1'b1;
			lq.scl_p <= 1'b1;
			lq.sda_s1 <= 1'b1;
			lq.sda_s2 <= 1'b1;
			lq.sda_p <= 1'b1;
			lq.ptr <= `PTR_RESET;
			lq.state <= eeprom_link_pkg::ST_IDLE;
		end else begin
			lq <= ld;
		end
	end

	// Array update only at end of the timed cycle, so reads never see half a page
	always_ff @(posedge link_clk_in) begin
		if (commit_w) begin
			for (int i = 0; i < 8; i++) begin
				if (lq.valid[i]) begin
					mem[{lq.ptr[7:3], 3'(i)}] <= lq.page_buf[i];
				end
			end
		end
	end

	// Write cycle timer on the system clock
	// Always the worst-case length: simpler than tracking a typical time
	always_comb begin
		sd = sq;
		sd.req_s1 = lq.req_tgl;
		sd.req_s2 = sq.req_s1;
		sd.req_p = sq.req_s2;
		if (sq.busy) begin
			if (sq.cnt == 24'(WR_CYCLES - 1)) begin
				sd.busy = 1'b0;
				sd.cnt = `TIMER_RESET;
				sd.done_tgl = ~sq.done_tgl;
			end else begin
				sd.cnt = sq.cnt + 24'h00_0001;
			end
		end else if (sq.req_s2 != sq.req_p) begin
			sd.busy = 1'b1;
			sd.cnt = `TIMER_RESET;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			sq <= '0;
		end else begin
			sq <= sd;
		end
	end

	a_start_ctrl: assert property (@(posedge link_clk_in) disable iff (!rst_l2)
		start_w |=> lq.state == eeprom_link_pkg::ST_CTRL && lq.cnt == `CNT_RESET)
		else $error("start did not open control byte");

	a_stop_idle: assert property (@(posedge link_clk_in) disable iff (!rst_l2)
		stop_w |=> lq.state == eeprom_link_pkg::ST_IDLE && !lq.sda_oe)
		else $error("stop did not release bus");

	a_drive_on_low: assert property (@(posedge link_clk_in) disable iff (!rst_l2)
		$rose(lq.sda_oe) |-> $past(fall_w))
		else $error("sda drive began outside clock low");

	a_busy_noack: assert property (@(posedge link_clk_in) disable iff (!rst_l2)
		lq.pend && lq.state == eeprom_link_pkg::ST_CTRL && fall_w && lq.cnt == `CNT_BYTE_DONE
		&& !start_w && !stop_w |=> !lq.sda_oe && lq.state == eeprom_link_pkg::ST_WAIT)
		else $error("acknowledge given while busy");

	a_match_ack: assert property (@(posedge link_clk_in) disable iff (!rst_l2)
		!lq.pend && ctrl_match_w && lq.state == eeprom_link_pkg::ST_CTRL && fall_w &&
		lq.cnt == `CNT_BYTE_DONE && !start_w && !stop_w |=> lq.sda_oe)
		else $error("matching control byte not acknowledged");

	a_addr_load: assert property (@(posedge link_clk_in) disable iff (!rst_l2)
		lq.state == eeprom_link_pkg::ST_ADDR && fall_w && lq.cnt == `CNT_BYTE_DONE &&
		!start_w && !stop_w |=> lq.ptr == $past(lq.shreg) && lq.state == eeprom_link_pkg::ST_WDATA)
		else $error("word address not loaded");

	a_page_inc: assert property (@(posedge link_clk_in) disable iff (!rst_l2)
		lq.state == eeprom_link_pkg::ST_WDATA && fall_w && lq.cnt == `CNT_BYTE_DONE &&
		!start_w && !stop_w |=> lq.ptr[7:3] == $past(lq.ptr[7:3]) &&
		lq.ptr[2:0] == 3'($past(lq.ptr[2:0]) + 3'h1))
		else $error("page pointer step wrong");

	a_commit_req: assert property (@(posedge link_clk_in) disable iff (!rst_l2)
		stop_w && lq.state == eeprom_link_pkg::ST_WDATA && lq.dirty && !lq.wp_s2 && !lq.pend
		|=> lq.pend && lq.req_tgl != $past(lq.req_tgl))
		else $error("stop after data did not launch write");

	a_wp_block: assert property (@(posedge link_clk_in) disable iff (!rst_l2)
		lq.wp_s2 |=> lq.req_tgl == $past(lq.req_tgl))
		else $error("write launched while protected");

	a_nack_release: assert property (@(posedge link_clk_in) disable iff (!rst_l2)
		lq.state == eeprom_link_pkg::ST_RDATA && rise_w && lq.cnt == `CNT_ACK_CLK && lq.sda_s2
		&& !start_w && !stop_w |=> lq.state == eeprom_link_pkg::ST_WAIT && !lq.sda_oe)
		else $error("sda not released after no acknowledge");

	a_rd_inc: assert property (@(posedge link_clk_in) disable iff (!rst_l2)
		lq.state == eeprom_link_pkg::ST_RDATA && fall_w && lq.cnt == `CNT_ACK_DONE &&
		!start_w && !stop_w |=> lq.ptr == 8'($past(lq.ptr) + 8'h01) && lq.cnt == `CNT_RESET)
		else $error("read pointer did not advance");

	a_timer_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(sq.busy) |-> sq.busy [*8])
		else $error("write cycle ended too soon");

	a_timer_done: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$fell(sq.busy) |-> sq.done_tgl != $past(sq.done_tgl))
		else $error("write cycle end not signalled");

	// Drive, pointer and page buffer checks on the link side
	a_idle_quiet: assert property (@(posedge link_clk_in) disable iff (!rst_l2)
		lq.state == eeprom_link_pkg::ST_IDLE |-> !lq.sda_oe)
		else $error("sda driven while idle");

	a_wait_quiet: assert property (@(posedge link_clk_in) disable iff (!rst_l2)
		lq.state == eeprom_link_pkg::ST_WAIT |-> !lq.sda_oe)
		else $error("sda driven while not addressed");

	a_oe_on_fall: assert property (@(posedge link_clk_in) disable iff (!rst_l2)
		$changed(lq.sda_oe) |-> $past(fall_w) || $past(start_w) || $past(stop_w))
		else $error("sda drive changed while clock high");

	a_ptr_stable: assert property (@(posedge link_clk_in) disable iff (!rst_l2)
		rise_w |=> $stable(lq.ptr))
		else $error("pointer moved on rising clock");

	a_commit_clear: assert property (@(posedge link_clk_in) disable iff (!rst_l2)
		lq.pend && lq.done_s2 != lq.done_p |=> !lq.pend && lq.valid == 8'h00)
		else $error("page buffer not emptied after commit");

	a_start_drop: assert property (@(posedge link_clk_in) disable iff (!rst_l2)
		start_w |=> !lq.dirty && !lq.sda_oe)
		else $error("start did not drop buffered write");

endmodule : i2c_eeprom_slave_256x8

`default_nettype wire

// file: test/i2c_master_model.sv
// Two-wire bus master model: drives the serial clock and pulls the data wire.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model (
	// Sampling clock
	input wire logic link_clk_in,
	// Bus
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_oe_out
);
	initial begin
		scl_out = 1'b1;
		sda_oe_out = 1'b0;
	end
	task automatic step(input int n);
		repeat (n) @(posedge link_clk_in);
		#1;
	endtask : step
	// Start, also repeated start from clock low
	task automatic bus_start();
		sda_oe_out = 1'b0;
		step(3);
		scl_out = 1'b1;
		step(6);
		sda_oe_out = 1'b1;
		step(6);
		scl_out = 1'b0;
	endtask : bus_start
	task automatic bus_stop();
		step(3);
		sda_oe_out = 1'b1;
		step(3);
		scl_out = 1'b1;
		step(6);
		sda_oe_out = 1'b0;
		step(6);
	endtask : bus_stop
	// Data moves only while clock low, one pulse per bit
	task automatic xfer_bit(input logic pull, output logic smp);
		step(3);
		sda_oe_out = pull;
		step(3);
		scl_out = 1'b1;
		step(3);
		smp = sda_in;
		step(3);
		scl_out = 1'b0;
	endtask : xfer_bit
	// MSB first, ninth clock for the device acknowledge
	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			xfer_bit(~d[i], b);
		end
		xfer_bit(1'b0, b);
		ack = ~b;
	endtask : put_byte
	// Acknowledge to continue, withhold on the last byte
	task automatic get_byte(input logic ack, output logic [7:0] d);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			xfer_bit(1'b0, d[i]);
		end
		xfer_bit(ack, b);
	endtask : get_byte
endmodule : i2c_master_model
`default_nettype wire

// file: test/i2c_eeprom_slave_256x8_tb.sv
// Self-checking bench for the two-wire memory slave, driven by a master model.
// Assumes design package, header and master model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module i2c_eeprom_slave_256x8_tb;
	// Short write time, still long enough to probe a refusal during it
	localparam int WR = 2000;
	localparam logic [2:0] SEL = 3'h5;
	logic clk_in, link_clk, rst_n, wp, scl, m_oe, dut_sda, dut_oe, busy, sda_w, ack;
	logic [7:0] mem [256];
	logic [7:0] ptr_m;
	int err_count = 0;
	int n_tests = 0;
	int busy_run = 0;
	int busy_len = 0;
	// Open drain with pull-up
	assign sda_w = ~(m_oe | dut_oe);
	// Busy pulse length in system cycles, sampled away from the launching edge
	always @(negedge clk_in) begin
		if (busy === 1'b1) begin
			busy_run <= busy_run + 1;
		end else begin
			if (busy_run != 0) busy_len <= busy_run;
			busy_run <= 0;
		end
	end
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	// Phase offset of 7 ns; every second rising link edge meets a system edge, alternately a rising and a falling one; no falling link edge does
	initial begin
		link_clk = 1'b0;
		#7;
		forever #15 link_clk = ~link_clk;
	end
	i2c_eeprom_slave_256x8 #(.WR_CYCLES(WR)) dut_u (.clk_in(clk_in), .rst_n_in(rst_n),
		.link_clk_in(link_clk), .scl_in(scl), .sda_in(sda_w), .sda_out(dut_sda),
		.sda_oe_out(dut_oe), .chip_sel_bit0_in(SEL[0]), .chip_sel_bit1_in(SEL[1]),
		.chip_sel_bit2_in(SEL[2]), .write_protect_in(wp), .busy_out(busy));
	i2c_master_model mst_u (.link_clk_in(link_clk), .sda_in(sda_w), .scl_out(scl),
		.sda_oe_out(m_oe));
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t byte %h expected %h", $time, got, exp);
		end
	endtask : chk_byte
	task automatic chk_bit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t bit %b expected %b", $time, got, exp);
		end
	endtask : chk_bit
	task automatic tally_and_finish();
		if (err_count == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : tally_and_finish
	function automatic logic [7:0] ctrl(input logic rd);
		return {4'ha, SEL, rd};
	endfunction : ctrl
	task automatic wait_busy(input logic lvl, input int lim);
		int k;
		k = 0;
		while (busy !== lvl && k < lim) begin
			@(posedge clk_in);
			#1;
			k++;
		end
		if (k >= lim) begin
			err_count++;
			$display("ERROR %0t busy wait timed out", $time);
			tally_and_finish();
		end
	endtask : wait_busy
	task automatic addr_set(input logic [7:0] a);
		mst_u.bus_start();
		mst_u.put_byte(ctrl(1'b0), ack);
		chk_bit(ack, 1'b1);
		mst_u.put_byte(a, ack);
		chk_bit(ack, 1'b1);
		ptr_m = a;
	endtask : addr_set
	task automatic do_write(input logic [7:0] a, input int n, input logic [7:0] d0);
		addr_set(a);
		for (int i = 0; i < n; i++) begin
			mst_u.put_byte(d0 + 8'(i), ack);
			chk_bit(ack, 1'b1);
			// Low pointer bits wrap inside the page
			if (wp === 1'b0) mem[{a[7:3], 3'(a[2:0] + 3'(i))}] = d0 + 8'(i);
		end
		mst_u.bus_stop();
		if (wp === 1'b1) begin
			repeat (200) @(posedge clk_in);
			#1;
			chk_bit(busy, 1'b0);
		end else begin
			wait_busy(1'b1, 200);
			mst_u.bus_start();
			mst_u.put_byte(ctrl(1'b0), ack);
			chk_bit(ack, 1'b0);
			mst_u.bus_stop();
			wait_busy(1'b0, WR + 50);
			repeat (10) @(posedge link_clk);
			#1;
			// Busy rises before the stop task returns, so its length comes from the monitor
			chk_bit(busy_len == WR, 1'b1);
		end
	endtask : do_write
	task automatic do_read(input logic rnd, input logic [7:0] a, input int n);
		logic [7:0] d;
		if (rnd === 1'b1) addr_set(a);
		mst_u.bus_start();
		mst_u.put_byte(ctrl(1'b1), ack);
		chk_bit(ack, 1'b1);
		for (int i = 0; i < n; i++) begin
			mst_u.get_byte(i < n - 1, d);
			chk_byte(d, mem[ptr_m]);
			ptr_m++;
		end
		chk_bit(dut_oe, 1'b0);
		mst_u.bus_stop();
		chk_bit(dut_oe, 1'b0);
	endtask : do_read
	task automatic sc_refuse();
		logic [7:0] bad [4];
		bad = '{{4'hb, SEL, 1'b0}, {4'ha, SEL ^ 3'h1, 1'b0}, {4'ha, SEL ^ 3'h2, 1'b1},
			{4'ha, SEL ^ 3'h4, 1'b0}};
		foreach (bad[i]) begin
			mst_u.bus_start();
			mst_u.put_byte(bad[i], ack);
			chk_bit(ack, 1'b0);
			mst_u.bus_stop();
		end
	endtask : sc_refuse
	// Ten bytes into one page, then sequential and current address reads
	task automatic sc_page();
		do_write(8'h1e, 10, 8'h40);
		do_read(1'b1, 8'h18, 7);
		do_read(1'b0, 8'h00, 1);
	endtask : sc_page
	task automatic sc_protect();
		wp = 1'b1;
		do_write(8'h18, 1, 8'h00);
		wp = 1'b0;
		do_read(1'b1, 8'h18, 1);
	endtask : sc_protect
	task automatic sc_wrap();
		do_write(8'hff, 1, 8'h5a);
		do_write(8'h00, 1, 8'hc3);
		do_read(1'b1, 8'hff, 2);
	endtask : sc_wrap
	initial begin
		rst_n = 1'b0;
		wp = 1'b0;
		repeat (10) @(posedge link_clk);
		@(posedge clk_in);
		#1;
		rst_n = 1'b1;
		repeat (8) @(posedge link_clk);
		#1;
		sc_refuse();
		sc_page();
		sc_protect();
		sc_wrap();
		chk_bit(dut_sda, 1'b0);
		tally_and_finish();
	end
endmodule : i2c_eeprom_slave_256x8_tb
`default_nettype wire
